/* core/dbs_consts.svh */
// constants of the dynamic bus sizing sequencer
`ifndef DBS_CONSTS_SVH
`define DBS_CONSTS_SVH

// ************************************************
// transfer-size codes (bytes still to move)
// ************************************************
`define DBS_SIZ_LONG  2'h0
`define DBS_SIZ_BYTE  2'h1
`define DBS_SIZ_WORD  2'h2
`define DBS_SIZ_THREE 2'h3

// ************************************************
// timing and long-transfer count
// ************************************************
`define DBS_CLK_PERIOD_NS 100
`define DBS_MIN_CYCLE_CLKS 3
`define DBS_CNT_LONG 3'h4

`endif

/* core/dbs_pkg.sv */
// types of the dynamic bus sizing sequencer
package dbs_pkg;

    typedef enum logic [1:0] {PORT_NONE, PORT_8, PORT_16} port_t;

    typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_SAMPLE, ST_TERM} bus_state_t;

endpackage

/* core/byte_lane_mux.sv */
// read lane selection for 8- and 16-bit ports
`timescale 1ns/100ps

module byte_lane_mux
(
    input  wire logic [15:0] data_in,
    input  wire logic        port8,
    input  wire logic        addr_odd,
    input  wire logic        single_byte,
    output logic      [15:0] lane_data,
    output logic             two_bytes
);

    // ************************************************
    // lane steering
    // ************************************************
    always_comb
    begin
        two_bytes = !port8 && !single_byte;
        if (two_bytes)
            lane_data = data_in;
        else if (!port8 && addr_odd)
            lane_data = {8'h00, data_in[7:0]};
        else
            lane_data = {8'h00, data_in[15:8]};
    end

endmodule

/* core/dynamic_bus_sizing_sequencer.sv */
// operand transfer sequencer with dynamic bus sizing
`timescale 1ns/100ps
`include "dbs_consts.svh"

module dynamic_bus_sizing_sequencer
(
    input  wire logic        ref_clk,
    input  wire logic        srst,
    input  wire logic        req_valid,
    input  wire logic        req_write,
    input  wire logic [1:0]  req_size,
    input  wire logic [31:0] req_addr,
    input  wire logic [31:0] req_wdata,
    output logic             req_ready,
    output logic             done,
    output logic             done_error,
    output logic      [31:0] rdata,
    output logic      [31:0] addr_out,
    output logic      [1:0]  xfer_size_out,
    output logic             rw_out,
    output logic             addr_strobe,
    output logic             data_strobe,
    input  wire logic [15:0] data_in,
    output logic      [15:0] data_out,
    output logic             data_oe,
    input  wire logic        ack_port8,
    input  wire logic        ack_port16,
    input  wire logic        bus_fault_in,
    input  wire logic        halt_in,
    input  wire logic        int_ack_en,
    input  wire logic        int_ack_port16
);

    // ************************************************
    // acknowledge decode
    // ************************************************
    function automatic dbs_pkg::port_t decode_ack(input logic a8, input logic a16);
        if (a16)
            decode_ack = dbs_pkg::PORT_16;
        else if (a8)
            decode_ack = dbs_pkg::PORT_8;
        else
            decode_ack = dbs_pkg::PORT_NONE;
    endfunction

    dbs_pkg::bus_state_t state;
    dbs_pkg::port_t      ack_now;
    dbs_pkg::port_t      port_seen;
    logic         [2:0]  cnt;
    logic         [31:0] obuf;
    logic         [31:0] rbuf;
    logic                is_write;
    logic                fault_seen;
    logic                fault_now;
    logic         [15:0] lane_data;
    logic                two_bytes;

    // internal acknowledge replaces the slave's when enabled
    assign ack_now = int_ack_en ? decode_ack(!int_ack_port16, int_ack_port16)
                                : decode_ack(ack_port8, ack_port16);
    assign fault_now = fault_seen || bus_fault_in;

    byte_lane_mux u_lanes
    (
        .data_in     (data_in),
        .port8       (port_seen == dbs_pkg::PORT_8),
        .addr_odd    (addr_out[0]),
        .single_byte (cnt == 3'h1),
        .lane_data   (lane_data),
        .two_bytes   (two_bytes)
    );

    // ************************************************
    // cycle state
    // ************************************************
    always_ff @(posedge ref_clk)
    begin
        if (srst)
            state <= dbs_pkg::ST_IDLE;
        else
            unique case (state)
                dbs_pkg::ST_IDLE:
                    if (req_valid)
                        state <= dbs_pkg::ST_ADDR;
                dbs_pkg::ST_ADDR:
                    state <= dbs_pkg::ST_SAMPLE;
                dbs_pkg::ST_SAMPLE:
                    if (bus_fault_in || ack_now != dbs_pkg::PORT_NONE)
                        state <= dbs_pkg::ST_TERM;
                dbs_pkg::ST_TERM:
                    if (fault_now)
                        state <= halt_in ? dbs_pkg::ST_ADDR : dbs_pkg::ST_IDLE;
                    else if (cnt <= (two_bytes ? 3'h2 : 3'h1))
                        state <= dbs_pkg::ST_IDLE;
                    else
                        state <= dbs_pkg::ST_ADDR;
            endcase
    end

    // ************************************************
    // port size and fault capture
    // ************************************************
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            port_seen  <= dbs_pkg::PORT_NONE;
            fault_seen <= 1'b0;
        end
        else if (state == dbs_pkg::ST_SAMPLE)
        begin
            port_seen  <= ack_now;
            fault_seen <= bus_fault_in;
        end
        else if (state == dbs_pkg::ST_ADDR)
        begin
            port_seen  <= dbs_pkg::PORT_NONE;
            fault_seen <= 1'b0;
        end
    end

    // ************************************************
    // size counter, address and operand buffers
    // ************************************************
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            cnt      <= 3'h0;
            addr_out <= 32'h0000_0000;
            obuf     <= 32'h0000_0000;
            is_write <= 1'b0;
        end
        else if (state == dbs_pkg::ST_IDLE && req_valid)
        begin
            cnt      <= (req_size == `DBS_SIZ_LONG) ? `DBS_CNT_LONG : {1'b0, req_size};
            addr_out <= req_addr;
            is_write <= req_write;
            unique case (req_size)
                `DBS_SIZ_BYTE: obuf <= {req_wdata[7:0], 24'h00_0000};
                `DBS_SIZ_WORD: obuf <= {req_wdata[15:0], 16'h0000};
                default:       obuf <= req_wdata;
            endcase
        end
        else if (state == dbs_pkg::ST_TERM && !fault_now)
        begin
            if (two_bytes)
            begin
                cnt      <= cnt - 3'h2;
                addr_out <= addr_out + 32'h0000_0002;
                obuf     <= {obuf[15:0], 16'h0000};
            end
            else
            begin
                cnt      <= cnt - 3'h1;
                addr_out <= addr_out + 32'h0000_0001;
                obuf     <= {obuf[23:0], 8'h00};
            end
        end
    end

    // ************************************************
    // read assembly, most significant byte first
    // ************************************************
    always_ff @(posedge ref_clk)
    begin
        if (srst)
            rbuf <= 32'h0000_0000;
        else if (state == dbs_pkg::ST_IDLE)
            rbuf <= 32'h0000_0000;
        else if (state == dbs_pkg::ST_TERM && !fault_now && !is_write)
            rbuf <= two_bytes ? {rbuf[15:0], lane_data} : {rbuf[23:0], lane_data[7:0]};
    end

    // ************************************************
    // completion to the requester
    // ************************************************
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            done       <= 1'b0;
            done_error <= 1'b0;
            rdata      <= 32'h0000_0000;
        end
        else
        begin
            done       <= 1'b0;
            done_error <= 1'b0;
            if (state == dbs_pkg::ST_TERM && fault_now && !halt_in)
            begin
                done       <= 1'b1;
                done_error <= 1'b1;
            end
            else if (state == dbs_pkg::ST_TERM && !fault_now
                     && cnt <= (two_bytes ? 3'h2 : 3'h1))
            begin
                done  <= 1'b1;
                rdata <= two_bytes ? {rbuf[15:0], lane_data}
                                   : {rbuf[23:0], lane_data[7:0]};
            end
        end
    end

    // ************************************************
    // bus outputs
    // ************************************************
    assign req_ready     = state == dbs_pkg::ST_IDLE;
    assign xfer_size_out = cnt[1:0];
    assign rw_out        = !is_write;
    assign addr_strobe   = state == dbs_pkg::ST_ADDR || state == dbs_pkg::ST_SAMPLE;
    assign data_strobe   = is_write ? state == dbs_pkg::ST_SAMPLE : addr_strobe;
    assign data_oe       = is_write && state != dbs_pkg::ST_IDLE;
    // single byte goes on both halves since port width is not yet known
    assign data_out      = (cnt == 3'h1) ? {obuf[31:24], obuf[31:24]}
                                         : obuf[31:16];

    // ************************************************
    // checks
    // ************************************************
    sequence s_strobe_run;
        addr_strobe [*2];
    endsequence

    property p_min_cycle;
        @(posedge ref_clk) disable iff (srst)
        $rose(addr_strobe) |-> s_strobe_run;
    endproperty
    a_min_cycle: assert property (p_min_cycle) else $error("cycle shorter than three clocks");

    property p_both_lanes;
        @(posedge ref_clk) disable iff (srst)
        data_oe && xfer_size_out == `DBS_SIZ_BYTE |-> data_out[15:8] == data_out[7:0];
    endproperty
    a_both_lanes: assert property (p_both_lanes) else $error("byte write not on both halves");

    property p_wait_ack;
        @(posedge ref_clk) disable iff (srst)
        state == dbs_pkg::ST_SAMPLE && ack_now == dbs_pkg::PORT_NONE && !bus_fault_in
        |=> state == dbs_pkg::ST_SAMPLE && addr_strobe;
    endproperty
    a_wait_ack: assert property (p_wait_ack) else $error("cycle ended without acknowledge");

    property p_byte_step;
        @(posedge ref_clk) disable iff (srst)
        state == dbs_pkg::ST_TERM && !fault_now && port_seen == dbs_pkg::PORT_8 && cnt > 3'h1
        |=> cnt == $past(cnt) - 3'h1 && addr_out == $past(addr_out) + 32'h0000_0001
            ##1 addr_strobe;
    endproperty
    a_byte_step: assert property (p_byte_step) else $error("8-bit port step wrong");

    property p_word_step;
        @(posedge ref_clk) disable iff (srst)
        state == dbs_pkg::ST_TERM && !fault_now && port_seen == dbs_pkg::PORT_16
        && cnt == `DBS_CNT_LONG
        |=> cnt == 3'h2 && addr_out == $past(addr_out) + 32'h0000_0002;
    endproperty
    a_word_step: assert property (p_word_step) else $error("16-bit long step wrong");

    property p_word_one;
        @(posedge ref_clk) disable iff (srst)
        state == dbs_pkg::ST_TERM && !fault_now && port_seen == dbs_pkg::PORT_16
        && cnt == 3'h2 |=> done && !done_error && req_ready;
    endproperty
    a_word_one: assert property (p_word_one) else $error("word to 16-bit port not one cycle");

    property p_retry;
        @(posedge ref_clk) disable iff (srst)
        state == dbs_pkg::ST_TERM && fault_now && halt_in
        |=> addr_strobe && !done && $stable(cnt) && $stable(addr_out);
    endproperty
    a_retry: assert property (p_retry) else $error("retry did not repeat the cycle");

    property p_abort;
        @(posedge ref_clk) disable iff (srst)
        state == dbs_pkg::ST_TERM && fault_now && !halt_in |=> done && done_error && req_ready;
    endproperty
    a_abort: assert property (p_abort) else $error("fault did not abort");

    property p_ds_in_as;
        @(posedge ref_clk) disable iff (srst)
        data_strobe |-> addr_strobe && (!is_write || data_oe);
    endproperty
    a_ds_in_as: assert property (p_ds_in_as) else $error("data strobe outside address strobe");

    property p_read8_lane;
        @(posedge ref_clk) disable iff (srst)
        state == dbs_pkg::ST_TERM && port_seen == dbs_pkg::PORT_8
        |-> lane_data[7:0] == data_in[15:8] && !two_bytes;
    endproperty
    a_read8_lane: assert property (p_read8_lane) else $error("8-bit port lane wrong");

    property p_odd_lane;
        @(posedge ref_clk) disable iff (srst)
        state == dbs_pkg::ST_TERM && port_seen == dbs_pkg::PORT_16 && cnt == 3'h1 && addr_out[0]
        |-> lane_data[7:0] == data_in[7:0];
    endproperty
    a_odd_lane: assert property (p_odd_lane) else $error("odd byte lane wrong");

endmodule

/* bench/slave_model.sv */
// behavioural 8/16-bit slave port answering with a port-size acknowledge
`timescale 1ns/100ps
`include "dbs_consts.svh"

module slave_model
(
    input  wire logic        ref_clk,
    input  wire logic        srst,
    input  wire logic        addr_strobe,
    input  wire logic        data_strobe,
    input  wire logic        rw_out,
    input  wire logic        port16,
    input  wire logic        mute,
    input  wire logic        fault_req,
    input  wire logic        halt_req,
    input  wire logic [1:0]  wait_n,
    input  wire logic [1:0]  xfer_size_out,
    input  wire logic [31:0] addr_out,
    input  wire logic [15:0] data_out,
    output logic      [15:0] data_in,
    output logic             ack_port8,
    output logic             ack_port16,
    output logic             bus_fault_in,
    output logic             halt_in
);
    logic [7:0] mem [64];
    logic [2:0] cnt;
    logic       hold;
    logic [5:0] a;

    assign a = addr_out[5:0];

    initial
    begin
        for (int i = 0; i < 64; i++)
            mem[i] = 8'(i) * 8'h1d ^ 8'h5a;
    end

    // ************************************************
    // answer after wait_n extra clocks, release after the strobe drops
    // ************************************************
    always @(posedge ref_clk)
    begin
        if (srst)
        begin
            {ack_port8, ack_port16, bus_fault_in, halt_in, hold} <= 5'h0;
            cnt <= 3'h0;
            data_in <= 16'h5aa5;
        end
        else if (addr_strobe)
        begin
            cnt <= cnt + 3'h1;
            if (cnt == {1'b0, wait_n})
            begin
                hold <= 1'b1;
                if (fault_req)
                    {bus_fault_in, halt_in} <= {1'b1, halt_req};
                else if (!mute)
                    {ack_port16, ack_port8} <= {port16, !port16};
                if (rw_out)
                    data_in <= port16 ? {mem[{a[5:1], 1'b0}], mem[{a[5:1], 1'b1}]}
                                      : {mem[a], ~data_in[7:0]};
            end
            else if (!hold)
                data_in <= ~data_in;
            if ((ack_port8 || ack_port16) && data_strobe && !rw_out)
            begin
                if (!port16)
                    mem[a] <= data_out[15:8];
                else if (xfer_size_out == `DBS_SIZ_BYTE)
                    mem[a] <= a[0] ? data_out[7:0] : data_out[15:8];
                else
                    {mem[{a[5:1], 1'b0}], mem[{a[5:1], 1'b1}]} <= data_out;
            end
        end
        else
        begin
            {ack_port8, ack_port16, bus_fault_in, halt_in, hold} <= 5'h0;
            cnt <= 3'h0;
            if (!hold)
                data_in <= ~data_in;
        end
    end
endmodule

/* bench/testbench.sv */
// self-checking bench of the dynamic bus sizing sequencer
`timescale 1ns/100ps
`include "dbs_consts.svh"

module testbench;
    logic        ref_clk = 1'b0;
    logic        srst = 1'b1;
    logic        req_valid = 1'b0;
    logic        req_write = 1'b0;
    logic [1:0]  req_size = `DBS_SIZ_BYTE;
    logic [31:0] req_addr = 32'h0000_0000;
    logic [31:0] req_wdata = 32'h0000_0000;
    logic        int_ack_en = 1'b0;
    logic        port16 = 1'b0;
    logic        mute = 1'b0;
    logic        fault_req = 1'b0;
    logic        halt_req = 1'b0;
    logic [1:0]  wait_n = 2'h0;
    logic        req_ready, done, done_error, rw_out, addr_strobe, data_strobe, data_oe;
    logic        ack_port8, ack_port16, bus_fault_in, halt_in;
    logic [31:0] rdata, addr_out;
    logic [1:0]  xfer_size_out;
    logic [15:0] data_in, data_out;
    logic [7:0]  shadow [64];
    logic [31:0] mon_addr [$];
    logic [1:0]  mon_size [$];
    logic [15:0] mon_data [$];
    int          mon_len [$];
    int          as_len = 0;
    logic        as_q = 1'b0;
    logic        seq_chk = 1'b1;
    int          n_fail = 0;
    int          tests_run = 0;

    always #50 ref_clk = ~ref_clk;

    dynamic_bus_sizing_sequencer dynamic_bus_sizing_sequencer_i (.ref_clk(ref_clk), .srst(srst),
        .req_valid(req_valid), .req_write(req_write), .req_size(req_size), .req_addr(req_addr),
        .req_wdata(req_wdata), .req_ready(req_ready), .done(done), .done_error(done_error),
        .rdata(rdata), .addr_out(addr_out), .xfer_size_out(xfer_size_out), .rw_out(rw_out),
        .addr_strobe(addr_strobe), .data_strobe(data_strobe), .data_in(data_in),
        .data_out(data_out), .data_oe(data_oe), .ack_port8(ack_port8), .ack_port16(ack_port16),
        .bus_fault_in(bus_fault_in), .halt_in(halt_in), .int_ack_en(int_ack_en),
        .int_ack_port16(port16));

    slave_model slave_model_i (.ref_clk(ref_clk), .srst(srst), .addr_strobe(addr_strobe),
        .data_strobe(data_strobe), .rw_out(rw_out), .port16(port16), .mute(mute),
        .fault_req(fault_req), .halt_req(halt_req), .wait_n(wait_n),
        .xfer_size_out(xfer_size_out), .addr_out(addr_out), .data_out(data_out),
        .data_in(data_in), .ack_port8(ack_port8), .ack_port16(ack_port16),
        .bus_fault_in(bus_fault_in), .halt_in(halt_in));

    // ************************************************
    // bus cycle monitor: one record per cycle, taken in the closing state
    // ************************************************
    always @(posedge ref_clk)
    begin
        as_q <= addr_strobe;
        if (addr_strobe)
            as_len <= as_len + 1;
        if (as_q && !addr_strobe)
        begin
            mon_addr.push_back(addr_out);
            mon_size.push_back(xfer_size_out);
            mon_data.push_back(data_out);
            mon_len.push_back(as_len);
            as_len <= 0;
        end
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic logic [7:0] opb(input logic [31:0] wd, input int nb, input int j);
        return 8'(wd >> (8 * (nb - 1 - j)));
    endfunction

    function automatic logic [31:0] exp_read(input int nb, input logic [31:0] a);
        logic [31:0] v;
        v = 32'h0000_0000;
        for (int i = 0; i < nb; i++)
            v = {v[23:0], shadow[6'(a + 32'(i))]};
        return v;
    endfunction

    task automatic run_op(input logic wr, input int nb, input logic [31:0] a,
                          input logic [31:0] wd, input logic p16, input logic [1:0] wt,
                          output logic [31:0] rd, output logic err);
        int          k;
        int          rem;
        logic [31:0] cur;
        logic [15:0] ex;
        logic [15:0] mask;
        @(posedge ref_clk);
        mon_addr.delete();
        mon_size.delete();
        mon_data.delete();
        mon_len.delete();
        port16 <= p16;
        wait_n <= wt;
        req_valid <= 1'b1;
        req_write <= wr;
        req_size <= nb == 4 ? `DBS_SIZ_LONG : nb == 2 ? `DBS_SIZ_WORD : `DBS_SIZ_BYTE;
        req_addr <= a;
        req_wdata <= wd;
        @(posedge ref_clk);
        req_valid <= 1'b0;
        k = 0;
        do
        begin
            @(posedge ref_clk);
            #1;
            k++;
            if (k > 300)
            begin
                n_fail++;
                test_done();
            end
        end
        while (done !== 1'b1);
        rd = rdata;
        err = done_error;
        if (seq_chk)
        begin
            rem = nb;
            cur = a;
            k = 0;
            while (rem > 0)
            begin
                check("bus address", mon_addr[k], cur);
                check("size code", 32'(mon_size[k]), 32'(rem[1:0]));
                check("strobe clocks", 32'(mon_len[k]), 32'(wt) + 2);
                ex = rem == 1 ? {opb(wd, nb, nb - rem), opb(wd, nb, nb - rem)}
                              : {opb(wd, nb, nb - rem), opb(wd, nb, nb - rem + 1)};
                mask = (p16 || rem == nb || rem == 1) ? 16'hffff : 16'hff00;
                if (wr)
                    check("write lanes", 32'(mon_data[k] & mask), 32'(ex & mask));
                cur = cur + ((p16 && rem > 1) ? 2 : 1);
                rem = rem - ((p16 && rem > 1) ? 2 : 1);
                k++;
            end
            check("bus cycles", 32'(mon_addr.size()), 32'(k));
        end
    endtask

    task automatic do_op(input logic wr, input int nb, input logic [31:0] a, input logic p16,
                         input logic [1:0] wt);
        logic [31:0] wd;
        logic [31:0] rd;
        logic        err;
        wd = $urandom;
        run_op(wr, nb, a, wd, p16, wt, rd, err);
        check("error flag", 32'(err), 32'h0000_0000);
        if (wr)
            for (int i = 0; i < nb; i++)
                shadow[6'(a + 32'(i))] = opb(wd, nb, i);
        else
            check("read data", rd, exp_read(nb, a));
    endtask

    initial
    begin
        int          r;
        int          k;
        logic [31:0] a;
        logic [31:0] rd;
        logic        err;
        void'($urandom(32'haf42e393));
        for (int i = 0; i < 64; i++)
            shadow[i] = 8'(i) * 8'h1d ^ 8'h5a;
        repeat (5) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        #1;
        check("idle strobes", 32'({req_ready, addr_strobe, data_oe}), 32'h0000_0004);
        for (int p = 0; p < 2; p++)
            for (int s = 0; s < 4; s++)
                for (int w = 1; w >= 0; w--)
                    do_op(w[0], s < 2 ? 1 : s * 2 - 2,
                          s == 0 ? 32'h0000_0110 : s == 1 ? 32'h0000_0111 :
                          s == 2 ? 32'h0000_0124 : 32'h0000_013c, p[0], s[1:0]);
        repeat (40)
        begin
            r = $urandom % 3;
            a = $urandom;
            if (r > 0)
                a[0] = 1'b0;
            do_op(1'($urandom % 2), 1 << r, a, 1'($urandom % 2), 2'($urandom % 4));
        end
        seq_chk = 0;
        @(posedge ref_clk);
        fault_req <= 1'b1;
        run_op(1'b0, 2, 32'h0000_0200, 32'h0000_0000, 1'b1, 2'h1, rd, err);
        check("abort flag", 32'(err), 32'h0000_0001);
        @(posedge ref_clk);
        halt_req <= 1'b1;
        fork
            run_op(1'b0, 4, 32'h0000_0208, 32'h0000_0000, 1'b0, 2'h0, rd, err);
            begin
                for (k = 0; k < 100 && bus_fault_in !== 1'b1; k++)
                    @(posedge ref_clk);
                fault_req <= 1'b0;
                halt_req <= 1'b0;
            end
        join
        check("retry flag", {31'h0, err}, 32'h0000_0000);
        check("fault raised", 32'(k < 100), 32'h0000_0001);
        check("retry data", rd, exp_read(4, 32'h0000_0208));
        @(posedge ref_clk);
        mute <= 1'b1;
        int_ack_en <= 1'b1;
        do_op(1'b0, 4, 32'h0000_0330, 1'b0, 2'h0);
        do_op(1'b0, 4, 32'h0000_0334, 1'b1, 2'h0);
        test_done();
    end
endmodule
